// [hdl/ipf_pkg.sv]
// Purpose: Shared constants for the interrupt priority and flag block
// Assumes: Avalon-MM slave with 32-bit data, word-aligned registers
// Notes: Registers hold 16 bits in the low lanes, upper bits read zero except at the status word, whose upper half holds the mask
package ipf_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] CTRL_TWO_OFS = 4'h0;
	localparam logic [3:0] FLAG_ZERO_OFS = 4'h4;
	localparam logic [3:0] PRIO_22_OFS = 4'h8;
	localparam logic [3:0] IRQ_STAT_OFS = 4'hc;
	localparam logic [15:0] CTRL_TWO_MASK = 16'h001f;
	localparam logic [15:0] FLAG_ZERO_MASK = 16'h0007;
	localparam logic [15:0] PRIO_22_MASK = 16'h7777;
	localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
	localparam logic [15:0] FLAG_ZERO_RST = 16'h0000;
	localparam logic [15:0] PRIO_22_RST = 16'h4444;
	localparam logic [15:0] IRQ_RST = 16'h0000;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int EXT_NUM = 5;
	localparam int EXT0_FLAG_BIT = 0;
	localparam int CAPTURE1_FLAG_BIT = 1;
	localparam int COMPARE1_FLAG_BIT = 2;
	localparam int RX4_LSB = 0;
	localparam int TX4_LSB = 4;
	localparam int SYNC3_GEN_LSB = 8;
	localparam int SYNC3_TX_LSB = 12;
	localparam int PRIO_W = 3;
	localparam int SRC_NUM = 4;
	localparam logic [2:0] PRIO_OFF = 3'h0;
endpackage : ipf_pkg

// [hdl/ipf_edge_det.sv]
// Purpose: Synchronise one external input and detect the chosen edge
// Assumes: Input is asynchronous to sys_clk
// Notes: Pulse lasts one cycle
`timescale 1ns/1ns
module ipf_edge_det (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin_in,
	input wire logic falling_sel,
	output logic edge_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	// Polarity 0 rising, 1 falling
	assign edge_pulse = falling_sel ? (last_q & ~sync_q)
		: (~last_q & sync_q);
endmodule : ipf_edge_det

// [hdl/ipf_top.sv]
// Purpose: Edge polarity, request flags and priority fields
// Assumes: Avalon-MM master honours waitrequest
// Notes: One wait cycle per access
// Function
// - One polarity bit per external input, bit 0 to bit 4
// - Polarity 0 detects rising edge, 1 detects falling edge
// - Flag reads 1 after a request, 0 if none since clearing
// - Compare channel one flag sits at bit 2
// - Capture channel one flag sits at bit 1
// - External input zero flag sits at bit 0
// - Three-bit priority field encodes level directly, 7 highest
// - Priority 000 disables the source, never presented
// - Serial four transmit priority at bits 6 to 4
// - Serial four receive priority at bits 2 to 0
// - Sync port three general at 10 to 8, transmit at 14 to 12
// - Unimplemented bits read zero, writes ignored
`timescale 1ns/1ns
module ipf_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [4:0] ext_in,
	input wire logic compare_one_req,
	input wire logic capture_one_req,
	input wire logic [3:0] src_req,
	output logic [3:0] src_pending,
	output logic [2:0] top_level,
	output logic irq
);
	// ****************************************
	// Registers and decode
	// ****************************************
	logic [15:0] ctrl_two_q;
	logic [15:0] flag_zero_q;
	logic [15:0] prio_22_q;
	logic [3:0] src_flag_q;
	logic [15:0] irq_mask_q;
	logic ack_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [3:0] pend_q;
	logic [2:0] lvl_q;
	logic irq_q;
	logic [4:0] ext_edge;
	wire access = (avs_read | avs_write) & ~ack_q;
	// Write lands at the edge that completes the handshake
	wire wr_en = avs_write & ack_q;
	wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] mask_be = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}};
	wire sel_ctrl = avs_address == ipf_pkg::CTRL_TWO_OFS;
	wire sel_flag = avs_address == ipf_pkg::FLAG_ZERO_OFS;
	wire sel_prio = avs_address == ipf_pkg::PRIO_22_OFS;
	wire sel_stat = avs_address == ipf_pkg::IRQ_STAT_OFS;
	wire [15:0] wdata = avs_writedata[15:0];
	// ****************************************
	// External edge detectors
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < ipf_pkg::EXT_NUM; gi++) begin : g_ext
			ipf_edge_det u_det (
				.sys_clk(sys_clk),
				.rst(rst),
				.pin_in(ext_in[gi]),
				.falling_sel(ctrl_two_q[gi]),
				.edge_pulse(ext_edge[gi])
			);
		end
	endgenerate
	// ****************************************
	// Flag update, set wins over clear
	// ****************************************
	wire [15:0] flag_set = {13'h0, compare_one_req, capture_one_req,
		ext_edge[0]};
	wire flag_wr = wr_en & sel_flag;
	wire [15:0] flag_keep = flag_wr ? (flag_zero_q & (wdata | ~be_mask))
		: flag_zero_q;
	wire [15:0] flag_d = (flag_keep | flag_set)
		& ipf_pkg::FLAG_ZERO_MASK;
	// Priority fields gate per-source requests
	wire [2:0] p_rx = prio_22_q[ipf_pkg::RX4_LSB +: ipf_pkg::PRIO_W];
	wire [2:0] p_tx = prio_22_q[ipf_pkg::TX4_LSB +: ipf_pkg::PRIO_W];
	wire [2:0] p_gen = prio_22_q[ipf_pkg::SYNC3_GEN_LSB +: ipf_pkg::PRIO_W];
	wire [2:0] p_stx = prio_22_q[ipf_pkg::SYNC3_TX_LSB +: ipf_pkg::PRIO_W];
	wire [3:0] src_en = {p_stx != ipf_pkg::PRIO_OFF,
		p_gen != ipf_pkg::PRIO_OFF, p_tx != ipf_pkg::PRIO_OFF,
		p_rx != ipf_pkg::PRIO_OFF};
	wire src_wr = wr_en & sel_stat;
	wire [3:0] src_keep = src_wr ? (src_flag_q & ~(wdata[3:0]
		& be_mask[3:0])) : src_flag_q;
	wire [3:0] src_d = src_keep | src_req;
	wire [3:0] pend_d = src_flag_q & src_en;
	// Highest level among pending sources
	wire [2:0] l0 = pend_d[0] ? p_rx : ipf_pkg::PRIO_OFF;
	wire [2:0] l1 = pend_d[1] ? p_tx : ipf_pkg::PRIO_OFF;
	wire [2:0] l2 = pend_d[2] ? p_gen : ipf_pkg::PRIO_OFF;
	wire [2:0] l3 = pend_d[3] ? p_stx : ipf_pkg::PRIO_OFF;
	wire [2:0] m01 = (l0 > l1) ? l0 : l1;
	wire [2:0] m23 = (l2 > l3) ? l2 : l3;
	wire [2:0] lvl_d = (m01 > m23) ? m01 : m23;
	wire [15:0] stat_view = {12'h000, src_flag_q};
	wire irq_d = |((flag_zero_q | {12'h000, pend_d}) & irq_mask_q);
	// Read mux, unmapped returns zero
	wire [15:0] rd_sel = sel_ctrl ? ctrl_two_q : sel_flag ? flag_zero_q
		: sel_prio ? prio_22_q : sel_stat ? stat_view
		: 16'h0000;
	// Mask register lives in the upper half of the status word
	wire [31:0] rd_word = sel_stat ? {irq_mask_q, rd_sel} : {16'h0000, rd_sel};
	// ****************************************
	// Sequential logic
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_two_q <= ipf_pkg::CTRL_TWO_RST;
			prio_22_q <= ipf_pkg::PRIO_22_RST;
			irq_mask_q <= ipf_pkg::IRQ_RST;
		end else if (wr_en) begin
			if (sel_ctrl)
				ctrl_two_q <= ((ctrl_two_q & ~be_mask) | (wdata & be_mask))
					& ipf_pkg::CTRL_TWO_MASK;
			if (sel_prio)
				prio_22_q <= ((prio_22_q & ~be_mask) | (wdata & be_mask))
					& ipf_pkg::PRIO_22_MASK;
			if (sel_stat)
				irq_mask_q <= (irq_mask_q & ~mask_be)
					| (avs_writedata[31:16] & mask_be);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flag_zero_q <= ipf_pkg::FLAG_ZERO_RST;
			src_flag_q <= 4'h0;
			pend_q <= 4'h0;
			lvl_q <= 3'h0;
			irq_q <= 1'b0;
		end else begin
			flag_zero_q <= flag_d;
			src_flag_q <= src_d;
			pend_q <= pend_d;
			lvl_q <= lvl_d;
			irq_q <= irq_d;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= access;
			wait_q <= ~access;
			rdata_q <= (avs_read & ~ack_q) ? rd_word : rdata_q;
		end
	end
	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;
	assign src_pending = pend_q;
	assign top_level = lvl_q;
	assign irq = irq_q;
	// ****************************************
	// Assertions
	// ****************************************
	property p_ctrl_zero;
		@(posedge sys_clk) disable iff (rst)
		ctrl_two_q[15:5] == 11'h000;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("control unimplemented bits set");
	property p_prio_reset;
		@(posedge sys_clk) $fell(rst) |-> prio_22_q == 16'h4444;
	endproperty
	a_prio_reset: assert property (p_prio_reset)
		else $error("priority reset value wrong");
	property p_compare_set;
		@(posedge sys_clk) disable iff (rst)
		compare_one_req |=> flag_zero_q[2];
	endproperty
	a_compare_set: assert property (p_compare_set)
		else $error("compare flag not set");
	property p_capture_set;
		@(posedge sys_clk) disable iff (rst)
		capture_one_req |=> flag_zero_q[1];
	endproperty
	a_capture_set: assert property (p_capture_set)
		else $error("capture flag not set");
	property p_ext0_set;
		@(posedge sys_clk) disable iff (rst)
		ext_edge[0] |=> flag_zero_q[0];
	endproperty
	a_ext0_set: assert property (p_ext0_set)
		else $error("external zero flag not set");
	property p_flag_hold;
		@(posedge sys_clk) disable iff (rst)
		flag_zero_q[0] & ~flag_wr |=> flag_zero_q[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without write");
	property p_flag_cause;
		@(posedge sys_clk) disable iff (rst)
		$rose(flag_zero_q[1]) |-> $past(capture_one_req);
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("flag rose without request");
	property p_disabled;
		@(posedge sys_clk) disable iff (rst)
		p_tx == 3'h0 |=> ~src_pending[1];
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled source presented");
	property p_level;
		@(posedge sys_clk) disable iff (rst)
		pend_d == 4'h1 |=> top_level == $past(p_rx);
	endproperty
	a_level: assert property (p_level)
		else $error("level mismatch");
	property p_wait;
		@(posedge sys_clk) disable iff (rst)
		access |=> ~avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait)
		else $error("bus handshake wrong");
	property p_ext0_clear;
		@(posedge sys_clk) disable iff (rst)
		flag_wr & be_mask[0] & ~wdata[0] & ~ext_edge[0]
			|=> ~flag_zero_q[0];
	endproperty
	a_ext0_clear: assert property (p_ext0_clear)
		else $error("external zero flag not cleared");
	property p_capture_clear;
		@(posedge sys_clk) disable iff (rst)
		flag_wr & be_mask[1] & ~wdata[1] & ~capture_one_req
			|=> ~flag_zero_q[1];
	endproperty
	a_capture_clear: assert property (p_capture_clear)
		else $error("capture flag not cleared");
	property p_compare_clear;
		@(posedge sys_clk) disable iff (rst)
		flag_wr & be_mask[2] & ~wdata[2] & ~compare_one_req
			|=> ~flag_zero_q[2];
	endproperty
	a_compare_clear: assert property (p_compare_clear)
		else $error("compare flag not cleared");
	property p_flag_zero;
		@(posedge sys_clk) disable iff (rst)
		flag_zero_q[15:3] == 13'h0;
	endproperty
	a_flag_zero: assert property (p_flag_zero)
		else $error("flag unimplemented bits set");
	property p_prio_gaps;
		@(posedge sys_clk) disable iff (rst)
		(prio_22_q & ~ipf_pkg::PRIO_22_MASK) == 16'h0000;
	endproperty
	a_prio_gaps: assert property (p_prio_gaps)
		else $error("priority unimplemented bits set");
	property p_rx_field;
		@(posedge sys_clk) disable iff (rst)
		wr_en & sel_prio & be_mask[0] |=> p_rx == $past(wdata[2:0]);
	endproperty
	a_rx_field: assert property (p_rx_field)
		else $error("receive priority field misplaced");
	property p_tx_field;
		@(posedge sys_clk) disable iff (rst)
		wr_en & sel_prio & be_mask[0] |=> p_tx == $past(wdata[6:4]);
	endproperty
	a_tx_field: assert property (p_tx_field)
		else $error("transmit priority field misplaced");
	property p_gen_field;
		@(posedge sys_clk) disable iff (rst)
		wr_en & sel_prio & be_mask[8] |=> p_gen == $past(wdata[10:8]);
	endproperty
	a_gen_field: assert property (p_gen_field)
		else $error("general priority field misplaced");
	property p_stx_field;
		@(posedge sys_clk) disable iff (rst)
		wr_en & sel_prio & be_mask[8] |=> p_stx == $past(wdata[14:12]);
	endproperty
	a_stx_field: assert property (p_stx_field)
		else $error("sync transmit priority field misplaced");
	property p_ctrl_write;
		@(posedge sys_clk) disable iff (rst)
		wr_en & sel_ctrl & be_mask[0]
			|=> ctrl_two_q[4:0] == $past(wdata[4:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("polarity bits not written");
	property p_pend_rx;
		@(posedge sys_clk) disable iff (rst)
		src_pending[0] |-> $past(p_rx) != ipf_pkg::PRIO_OFF;
	endproperty
	a_pend_rx: assert property (p_pend_rx)
		else $error("disabled receive source pending");
	property p_irq_disabled;
		@(posedge sys_clk) disable iff (rst)
		src_en == 4'h0 && flag_zero_q == 16'h0000 |=> ~irq;
	endproperty
	a_irq_disabled: assert property (p_irq_disabled)
		else $error("disabled sources raised interrupt");
	property p_level_top;
		@(posedge sys_clk) disable iff (rst)
		src_pending[3] |-> top_level >= $past(p_stx);
	endproperty
	a_level_top: assert property (p_level_top)
		else $error("level below pending source");
	property p_level_zero;
		@(posedge sys_clk) disable iff (rst)
		src_pending == 4'h0 |-> top_level == 3'h0;
	endproperty
	a_level_zero: assert property (p_level_zero)
		else $error("level set with nothing pending");
	property p_read_zero;
		@(posedge sys_clk) disable iff (rst)
		access & avs_read & ~(sel_ctrl | sel_flag | sel_prio | sel_stat)
			|=> avs_readdata == 32'h00000000;
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("unmapped read not zero");
endmodule : ipf_top

// [sim/ipf_src_model.sv]
// Purpose: Peripheral request sources
// Assumes: Changes land after sys_clk rises
// Notes: Request pulses last one cycle
`timescale 1ns/1ns
module ipf_src_model (
	input wire logic sys_clk,
	output logic [4:0] ext_in,
	output logic compare_one_req,
	output logic capture_one_req,
	output logic [3:0] src_req
);
	initial begin
		ext_in = 5'h00;
		compare_one_req = 1'b0;
		capture_one_req = 1'b0;
		src_req = 4'h0;
	end
	// Compare, capture, then the four sources
	task automatic pulse(input logic [5:0] v);
		@(posedge sys_clk);
		{compare_one_req, capture_one_req, src_req} <= v;
		@(posedge sys_clk);
		{compare_one_req, capture_one_req, src_req} <= 6'h00;
	endtask : pulse
	task automatic set_ext(input logic [4:0] v);
		@(posedge sys_clk);
		ext_in <= v;
	endtask : set_ext
endmodule : ipf_src_model

// [sim/interrupt_priority_and_flags_tb.sv]
// Purpose: Register, flag and priority checks
// Assumes: One wait cycle per bus access
// Notes: Expected values from the field layout
`timescale 1ns/1ns
module interrupt_priority_and_flags_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [4:0] ext_in;
	logic compare_one_req;
	logic capture_one_req;
	logic [3:0] src_req;
	logic [3:0] src_pending;
	logic [2:0] top_level;
	logic irq;
	logic [31:0] outs;
	int mismatches = 0;
	int checks = 0;
	assign outs = {24'h0, irq, src_pending, top_level};
	always #20 sys_clk = ~sys_clk;
	ipf_src_model src (.sys_clk(sys_clk), .ext_in(ext_in),
		.compare_one_req(compare_one_req),
		.capture_one_req(capture_one_req), .src_req(src_req));
	ipf_top dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_in(ext_in), .compare_one_req(compare_one_req),
		.capture_one_req(capture_one_req), .src_req(src_req),
		.src_pending(src_pending), .top_level(top_level), .irq(irq));
	task automatic summarize();
		if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	// ******
	// Bus access
	// ******
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			summarize();
		end
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask : wr
	task automatic wrb(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask : wrb
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask : rd
	task automatic ext(input logic [4:0] v, input logic [31:0] e);
		src.set_ext(v);
		repeat (4) @(posedge sys_clk);
		rd(4'h4, e);
	endtask : ext
	task automatic outs_chk(input logic [31:0] e);
		repeat (3) @(posedge sys_clk);
		chk(outs, e);
	endtask : outs_chk
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h4444);
		chk(outs, 32'h0);
		wr(4'h0, 32'hffffffff);
		rd(4'h0, 32'h1f);
		rd(4'h2, 32'h0);
		wr(4'h8, 32'hffffffff);
		rd(4'h8, 32'h7777);
		wr(4'h8, 32'h7531);
		rd(4'h8, 32'h7531);
		wrb(4'h8, 32'h0, 4'h1);
		rd(4'h8, 32'h7500);
		wr(4'h0, 32'h0);
		wr(4'h4, 32'h0);
		src.pulse(6'h20);
		rd(4'h4, 32'h4);
		src.pulse(6'h10);
		rd(4'h4, 32'h6);
		wrb(4'h4, 32'h0, 4'h2);
		rd(4'h4, 32'h6);
		wr(4'h4, 32'h3);
		rd(4'h4, 32'h2);
		wr(4'h4, 32'h0);
		wr(4'h4, 32'h7);
		rd(4'h4, 32'h0);
		ext(5'h01, 32'h1);
		wr(4'h4, 32'h0);
		ext(5'h00, 32'h0);
		wr(4'h0, 32'h1);
		wr(4'h4, 32'h0);
		ext(5'h01, 32'h0);
		ext(5'h00, 32'h1);
		wr(4'h4, 32'h0);
		wr(4'h8, 32'h0003);
		src.pulse(6'h0f);
		outs_chk(32'h0b);
		wr(4'h8, 32'h7531);
		outs_chk(32'h7f);
		wr(4'h8, 32'h1000);
		outs_chk(32'h41);
		rd(4'hc, 32'h000f);
		wr(4'hc, 32'h00080000);
		outs_chk(32'hc1);
		wr(4'hc, 32'h0008000f);
		outs_chk(32'h0);
		wr(4'h8, 32'h0);
		src.pulse(6'h08);
		outs_chk(32'h0);
		rd(4'hc, 32'h00080008);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(4'h8, 32'h4444);
		rd(4'hc, 32'h0);
		chk(outs, 32'h0);
		summarize();
	end
endmodule : interrupt_priority_and_flags_tb
